// ### src/serial_clock_divider_select.sv
// Serial clock divider select: one prescaler counter on the system
// clock, two rate taps (channel 0 and channel 1) chosen by software.
// Assumes clk is the oscillator clock and all inputs are synchronous.
`timescale 1ns/1ns
module serial_clock_divider_select
  import serial_clock_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regReadData,
  output logic ch0ShiftTick,
  output logic ch1ShiftTick,
  output logic ch0BusMode,
  output logic [DATA_W-1:0] busInterfaceControl,
  output logic [DATA_W-1:0] interruptTiming
);

  // ----------------------------------------------------------
  // Rate decode
  // ----------------------------------------------------------
  // Returns the power of two below the oscillator, or 0 when the
  // code is barred; a zero exponent keeps the tap silent.
  function automatic logic [3:0] rateExp(
    input logic [3:0] code,
    input logic [3:0] offset,
    input logic fullOsc
  );
    logic barred;
    barred = (code < RATE_CODE_MIN) || (code > RATE_CODE_MAX) ||
             (fullOsc && (code == RATE_CODE_MIN));
    if (barred) begin
      rateExp = 4'h0;
    end else begin
      rateExp = code - offset + {3'h0, ~fullOsc};
    end
  endfunction

  // All-ones in the low exp bits of the prescaler
  function automatic logic [DIV_W-1:0] tapMask(input logic [3:0] exp);
    tapMask = ~({DIV_W{1'b1}} << exp);
  endfunction

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  logic [7:0] serialClockSelect;
  logic [7:0] ch0OperatingMode;
  logic [7:0] oscillationMode;
  logic [DIV_W-1:0] divCount;

  wire selWrite = regWrite && (regAddr == ADDR_SERIAL_CLOCK_SELECT);
  wire modeWrite = regWrite && (regAddr == ADDR_CH0_OPERATING_MODE);
  wire bicWrite = regWrite && (regAddr == ADDR_BUS_INTERFACE_CONTROL);
  wire itWrite = regWrite && (regAddr == ADDR_INTERRUPT_TIMING);
  wire oscWrite = regWrite && (regAddr == ADDR_OSCILLATION_MODE);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serialClockSelect <= RESET_SERIAL_CLOCK_SELECT;
      ch0OperatingMode <= RESET_CH0_OPERATING_MODE;
      busInterfaceControl <= RESET_BUS_INTERFACE_CONTROL;
      interruptTiming <= RESET_INTERRUPT_TIMING;
      oscillationMode <= RESET_OSCILLATION_MODE;
    end else begin
      // Whole-byte write only; software must stop transfers first
      if (selWrite) begin
        serialClockSelect <= regWriteData;
      end
      if (modeWrite) begin
        ch0OperatingMode <= regWriteData;
      end
      if (bicWrite) begin
        busInterfaceControl <= regWriteData;
      end
      if (itWrite) begin
        interruptTiming <= regWriteData;
      end
      if (oscWrite) begin
        oscillationMode <= regWriteData;
      end
    end
  end

  // ----------------------------------------------------------
  // Rate selection
  // ----------------------------------------------------------
  wire oscHalvingSelect = oscillationMode[OSC_HALVING_SELECT_BIT];
  wire [3:0] ch0Code = serialClockSelect[CH0_RATE_BIT0 +: 4];
  wire [3:0] ch1Code = serialClockSelect[CH1_RATE_BIT0 +: 4];
  wire busMode = ch0OperatingMode[CH0_BUS_MODE_BIT];
  wire [3:0] ch0Offset = busMode ? BUS_MODE_OFFSET : SHIFT_MODE_OFFSET;
  wire [3:0] ch0Exp = rateExp(ch0Code, ch0Offset, oscHalvingSelect);
  wire [3:0] ch1Exp = rateExp(ch1Code, SHIFT_MODE_OFFSET, oscHalvingSelect);
  wire [DIV_W-1:0] ch0Mask = tapMask(ch0Exp);
  wire [DIV_W-1:0] ch1Mask = tapMask(ch1Exp);
  // Taps instead of derived clocks keep everything on one clock tree
  wire next_ch0ShiftTick = (ch0Exp != 4'h0) && ((divCount & ch0Mask) == ch0Mask);
  wire next_ch1ShiftTick = (ch1Exp != 4'h0) && ((divCount & ch1Mask) == ch1Mask);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divCount <= '0;
      ch0ShiftTick <= 1'b0;
      ch1ShiftTick <= 1'b0;
    end else begin
      divCount <= divCount + {{(DIV_W-1){1'b0}}, 1'b1};
      ch0ShiftTick <= next_ch0ShiftTick;
      ch1ShiftTick <= next_ch1ShiftTick;
    end
  end

  assign ch0BusMode = busMode;

  // ----------------------------------------------------------
  // Read port
  // ----------------------------------------------------------
  wire [7:0] rateStatus = {6'h00, ch1Exp == 4'h0, ch0Exp == 4'h0};
  logic [7:0] readMux;
  always_comb begin
    case (regAddr)
      ADDR_SERIAL_CLOCK_SELECT: readMux = serialClockSelect;
      ADDR_CH0_OPERATING_MODE: readMux = ch0OperatingMode;
      ADDR_BUS_INTERFACE_CONTROL: readMux = busInterfaceControl;
      ADDR_INTERRUPT_TIMING: readMux = interruptTiming;
      ADDR_OSCILLATION_MODE: readMux = oscillationMode;
      ADDR_RATE_STATUS: readMux = rateStatus;
      default: readMux = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regReadData <= 8'h00;
    end else begin
      regReadData <= regRead ? readMux : 8'h00;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  // Gap counters measure tick spacing; a config write and the cycle
  // after it disarm them, since the old rate may still emit one tick.
  logic cfgWriteD;
  logic selWritten;
  logic [13:0] ch0Gap;
  logic [13:0] ch1Gap;
  logic ch0Armed;
  logic ch1Armed;
  wire cfgClear = selWrite || modeWrite || oscWrite || cfgWriteD;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfgWriteD <= 1'b0;
      selWritten <= 1'b0;
      ch0Gap <= 14'h0000;
      ch1Gap <= 14'h0000;
      ch0Armed <= 1'b0;
      ch1Armed <= 1'b0;
    end else begin
      cfgWriteD <= selWrite || modeWrite || oscWrite;
      selWritten <= selWritten || selWrite;
      ch0Gap <= (cfgClear || ch0ShiftTick) ? 14'h0000 : ch0Gap + 14'h0001;
      ch1Gap <= (cfgClear || ch1ShiftTick) ? 14'h0000 : ch1Gap + 14'h0001;
      ch0Armed <= cfgClear ? 1'b0 : (ch0Armed || ch0ShiftTick);
      ch1Armed <= cfgClear ? 1'b0 : (ch1Armed || ch1ShiftTick);
    end
  end

  wire [3:0] chkHalf = {3'h0, ~oscHalvingSelect};
  wire [3:0] ch0BusPow = ch0Code - 4'h1 + chkHalf;
  wire [3:0] ch0ShiftPow = ch0Code - 4'h5 + chkHalf;
  wire [3:0] ch1Pow = ch1Code - 4'h5 + chkHalf;
  wire [13:0] ch0BusGap = (14'h0001 << ch0BusPow) - 14'h0001;
  wire [13:0] ch0ShiftGap = (14'h0001 << ch0ShiftPow) - 14'h0001;
  wire [13:0] ch1ExpGap = (14'h0001 << ch1Pow) - 14'h0001;
  // Barred-code decode kept apart from rateExp so the checks do not echo it
  wire ch0BarredChk = (ch0Code < 4'h6) || (ch0Code > 4'hD) ||
                      (oscHalvingSelect && (ch0Code == 4'h6));
  wire ch1BarredChk = (ch1Code < 4'h6) || (ch1Code > 4'hD) ||
                      (oscHalvingSelect && (ch1Code == 4'h6));

  sequence modeRead;
    regRead && (regAddr == ADDR_CH0_OPERATING_MODE);
  endsequence

  sequence modeAnswer;
    regReadData == ch0OperatingMode;
  endsequence

  a_ch0_bus_period: assert property (@(posedge clk) disable iff (!resetn)
    ch0ShiftTick && ch0Armed && !cfgClear && busMode |-> ch0Gap == ch0BusGap)
    else $error("channel 0 bus mode tick spacing wrong");

  a_ch0_shift_period: assert property (@(posedge clk) disable iff (!resetn)
    ch0ShiftTick && ch0Armed && !cfgClear && !busMode |-> ch0Gap == ch0ShiftGap)
    else $error("channel 0 shift mode tick spacing wrong");

  a_ch1_tick_period: assert property (@(posedge clk) disable iff (!resetn)
    ch1ShiftTick && ch1Armed && !cfgClear |-> ch1Gap == ch1ExpGap)
    else $error("channel 1 tick spacing wrong");

  a_barred_code_silent: assert property (@(posedge clk) disable iff (!resetn)
    oscHalvingSelect && (ch1Code == 4'h6) && $stable(serialClockSelect)
      && $stable(oscillationMode) |=> !ch1ShiftTick)
    else $error("barred channel 1 code produced a tick");

  a_select_reset_value: assert property (@(posedge clk) disable iff (!resetn)
    !selWritten |-> serialClockSelect == 8'h88)
    else $error("clock select lost its reset value");

  a_mode_read_back: assert property (@(posedge clk) disable iff (!resetn)
    modeRead ##0 !modeWrite ##1 !$past(modeWrite) |-> modeAnswer)
    else $error("mode register read back wrong");

  a_halving_bit_write: assert property (@(posedge clk) disable iff (!resetn)
    oscWrite |=> oscHalvingSelect == $past(regWriteData[0]))
    else $error("halving bit not taken from bit 0");

  a_tick_one_cycle: assert property (@(posedge clk) disable iff (!resetn)
    ch0ShiftTick && !cfgClear |=> !ch0ShiftTick)
    else $error("channel 0 tick longer than one cycle");

  // ----------------------------------------------------------
  // Register and tap checks
  // ----------------------------------------------------------
  a_ch1_tick_one: assert property (@(posedge clk) disable iff (!resetn)
    ch1ShiftTick && !cfgClear |=> !ch1ShiftTick)
    else $error("channel 1 tick longer than one cycle");

  a_ch0_tick_aligned: assert property (@(posedge clk) disable iff (!resetn)
    ch0ShiftTick |-> divCount[0] == 1'b0)
    else $error("channel 0 tick off the prescaler tap");

  a_ch1_tick_aligned: assert property (@(posedge clk) disable iff (!resetn)
    ch1ShiftTick |-> divCount[0] == 1'b0)
    else $error("channel 1 tick off the prescaler tap");

  // Reset codes 8/8 with halving bit 0 give a tick every 16 cycles
  a_ch0_reset_rate: assert property (@(posedge clk) disable iff (!resetn)
    ch0ShiftTick && !selWritten && !cfgClear && !busMode && !oscHalvingSelect
      |-> divCount[3:0] == 4'h0)
    else $error("channel 0 reset rate wrong");

  a_ch1_reset_rate: assert property (@(posedge clk) disable iff (!resetn)
    ch1ShiftTick && !selWritten && !cfgClear && !oscHalvingSelect
      |-> divCount[3:0] == 4'h0)
    else $error("channel 1 reset rate wrong");

  a_read_idle_zero: assert property (@(posedge clk) disable iff (!resetn)
    !regRead |=> regReadData == 8'h00)
    else $error("read data not zero outside a read");

  a_select_read_back: assert property (@(posedge clk) disable iff (!resetn)
    regRead && (regAddr == ADDR_SERIAL_CLOCK_SELECT) && !selWrite
      |=> regReadData == serialClockSelect)
    else $error("clock select read back wrong");

  a_select_whole_byte: assert property (@(posedge clk) disable iff (!resetn)
    selWrite |=> serialClockSelect == $past(regWriteData))
    else $error("clock select not written as a whole byte");

  a_bus_ctrl_write: assert property (@(posedge clk) disable iff (!resetn)
    bicWrite |=> busInterfaceControl == $past(regWriteData))
    else $error("bus interface control write lost");

  a_timing_write: assert property (@(posedge clk) disable iff (!resetn)
    itWrite |=> interruptTiming == $past(regWriteData))
    else $error("interrupt timing write lost");

  a_mode_bit_write: assert property (@(posedge clk) disable iff (!resetn)
    modeWrite |=> ch0BusMode == $past(regWriteData[0]))
    else $error("bus mode bit not taken from bit 0");

  a_osc_read_back: assert property (@(posedge clk) disable iff (!resetn)
    regRead && (regAddr == ADDR_OSCILLATION_MODE) && !oscWrite
      |=> regReadData == oscillationMode)
    else $error("oscillation mode read back wrong");

  a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!resetn)
    regRead && (regAddr == 16'hFF00) |=> regReadData == 8'h00)
    else $error("unmapped read not zero");

  a_ch0_status_bit: assert property (@(posedge clk) disable iff (!resetn)
    regRead && (regAddr == ADDR_RATE_STATUS) |=> regReadData[0] == $past(ch0BarredChk))
    else $error("channel 0 barred status wrong");

  a_ch1_status_bit: assert property (@(posedge clk) disable iff (!resetn)
    regRead && (regAddr == ADDR_RATE_STATUS) |=> regReadData[1] == $past(ch1BarredChk))
    else $error("channel 1 barred status wrong");

  a_ch0_barred_silent: assert property (@(posedge clk) disable iff (!resetn)
    ch0BarredChk && $stable(serialClockSelect) && $stable(oscillationMode)
      |=> !ch0ShiftTick)
    else $error("barred channel 0 code produced a tick");

  a_ch1_range_silent: assert property (@(posedge clk) disable iff (!resetn)
    ch1BarredChk && $stable(serialClockSelect) && $stable(oscillationMode)
      |=> !ch1ShiftTick)
    else $error("out of range channel 1 code produced a tick");

endmodule

// ### src/serial_clock_pkg.sv
// Shared constants for the serial clock divider select block.
// Assumes an 8-bit register port with 16-bit byte addresses.
package serial_clock_pkg;

  // ----------------------------------------------------------
  // Register map
  // ----------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] ADDR_SERIAL_CLOCK_SELECT = 16'hFF43;
  localparam logic [15:0] ADDR_CH0_OPERATING_MODE = 16'hFF60;
  localparam logic [15:0] ADDR_BUS_INTERFACE_CONTROL = 16'hFF61;
  localparam logic [15:0] ADDR_INTERRUPT_TIMING = 16'hFF62;
  localparam logic [15:0] ADDR_OSCILLATION_MODE = 16'hFF70;
  localparam logic [15:0] ADDR_RATE_STATUS = 16'hFF71;

  // ----------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------
  localparam logic [7:0] RESET_SERIAL_CLOCK_SELECT = 8'h88;
  localparam logic [7:0] RESET_CH0_OPERATING_MODE = 8'h00;
  localparam logic [7:0] RESET_BUS_INTERFACE_CONTROL = 8'h00;
  localparam logic [7:0] RESET_INTERRUPT_TIMING = 8'h00;
  localparam logic [7:0] RESET_OSCILLATION_MODE = 8'h00;

  // ----------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------
  localparam int CH0_RATE_BIT0 = 0;
  localparam int CH1_RATE_BIT0 = 4;
  localparam int OSC_HALVING_SELECT_BIT = 0;
  localparam int CH0_BUS_MODE_BIT = 0;
  localparam int STATUS_CH0_PROHIBITED_BIT = 0;
  localparam int STATUS_CH1_PROHIBITED_BIT = 1;

  // ----------------------------------------------------------
  // Rate codes and divider
  // ----------------------------------------------------------
  localparam logic [3:0] RATE_CODE_MIN = 4'h6;
  localparam logic [3:0] RATE_CODE_MAX = 4'hD;
  // Code minus this offset gives the power of two below fxx
  localparam logic [3:0] BUS_MODE_OFFSET = 4'h1;
  localparam logic [3:0] SHIFT_MODE_OFFSET = 4'h5;
  localparam int DIV_W = 13;

endpackage

// ### verif/serial_clock_divider_select_bench.sv
// Self-checking bench for the serial clock divider select block.
// Assumes the design package and a single 125 MHz clock.
`timescale 1ns/1ns
module serial_clock_divider_select_bench;
  import serial_clock_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWriteData = '0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [DATA_W-1:0] regReadData;
  logic ch0ShiftTick;
  logic ch1ShiftTick;
  logic ch0BusMode;
  logic [DATA_W-1:0] busInterfaceControl;
  logic [DATA_W-1:0] interruptTiming;
  int badCount = 0;
  int checksDone = 0;
  logic [3:0] hi;

  always #4 clk = ~clk;

  serial_clock_divider_select serial_clock_divider_select_inst (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .ch0ShiftTick(ch0ShiftTick), .ch1ShiftTick(ch1ShiftTick), .ch0BusMode(ch0BusMode),
    .busInterfaceControl(busInterfaceControl), .interruptTiming(interruptTiming)
  );

  // ----------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input string what, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, regReadData});
    @(posedge clk);
    #1;
    chk("read idle", 16'h0000, {8'h00, regReadData});
  endtask

  function automatic logic tick(input bit ch);
    return ch ? ch1ShiftTick : ch0ShiftTick;
  endfunction

  // Skips one tick first: the period after a code change is partial
  task automatic rate(input string what, input bit ch, input int e);
    int i;
    @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      i = 0;
      do begin
        @(posedge clk);
        #1;
        i++;
      end while (tick(ch) !== 1'b1 && i < 20000);
    end
    chk(what, 16'h0001 << e, i[15:0]);
  endtask

  task automatic silent(input string what, input bit ch);
    logic [15:0] n;
    n = '0;
    @(posedge clk);
    repeat (600) begin
      @(posedge clk);
      #1;
      if (tick(ch) !== 1'b0) n++;
    end
    chk(what, 16'h0000, n);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd("clock select", ADDR_SERIAL_CLOCK_SELECT, 8'h88);
    rd("osc mode", ADDR_OSCILLATION_MODE, 8'h00);
    rate("ch0 reset", 1'b0, 4);
    rate("ch1 reset", 1'b1, 4);
    wr(ADDR_BUS_INTERFACE_CONTROL, 8'hA5);
    wr(ADDR_INTERRUPT_TIMING, 8'h5A);
    wr(ADDR_RATE_STATUS, 8'hFF);
    rd("bus control", ADDR_BUS_INTERFACE_CONTROL, 8'hA5);
    rd("int timing", ADDR_INTERRUPT_TIMING, 8'h5A);
    chk("bus control port", 16'h00A5, {8'h00, busInterfaceControl});
    chk("int timing port", 16'h005A, {8'h00, interruptTiming});
    rd("status", ADDR_RATE_STATUS, 8'h00);
    rd("unmapped", 16'hFF00, 8'h00);
    // Every legal ch0 code in each mode and halving setting; ch1 misses code 7 at halving 1, nibbles differ except D/D
    for (int h = 0; h < 2; h++) begin
      wr(ADDR_OSCILLATION_MODE, 8'(h));
      for (int m = 0; m < 2; m++) begin
        wr(ADDR_CH0_OPERATING_MODE, 8'(m));
        #1;
        chk("bus mode port", 16'(m), {15'h0000, ch0BusMode});
        rd("mode reg", ADDR_CH0_OPERATING_MODE, 8'(m));
        for (int c = 6; c < 14; c++) begin
          if (h == 1 && c == 6) continue;
          hi = (c == 13) ? ((h == 1) ? 4'hD : 4'h6) : 4'(c + 1);
          wr(ADDR_SERIAL_CLOCK_SELECT, {hi, 4'(c)});
          rate("ch0 rate", 1'b0, c - h - ((m == 1) ? 0 : 4));
          rate("ch1 rate", 1'b1, int'(hi) - 4 - h);
        end
      end
    end
    // Barred codes are stored but silence the taps
    wr(ADDR_SERIAL_CLOCK_SELECT, 8'h66);
    silent("ch0 code 6 full", 1'b0);
    silent("ch1 code 6 full", 1'b1);
    rd("status 66", ADDR_RATE_STATUS, 8'h03);
    wr(ADDR_OSCILLATION_MODE, 8'h00);
    wr(ADDR_SERIAL_CLOCK_SELECT, 8'hF0);
    silent("ch0 code 0", 1'b0);
    silent("ch1 code F", 1'b1);
    rd("select F0", ADDR_SERIAL_CLOCK_SELECT, 8'hF0);
    wr(ADDR_OSCILLATION_MODE, 8'h01);
    wr(ADDR_SERIAL_CLOCK_SELECT, 8'h86);
    silent("ch0 only barred", 1'b0);
    rate("ch1 beside barred", 1'b1, 3);
    rd("status 86", ADDR_RATE_STATUS, 8'h01);
    // Second reset in mid-run
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd("select again", ADDR_SERIAL_CLOCK_SELECT, 8'h88);
    rd("osc again", ADDR_OSCILLATION_MODE, 8'h00);
    rate("ch0 again", 1'b0, 4);
    results();
  end

  // Longest legal sweep is about 50000 cycles
  initial begin
    #(8 * 90000);
    badCount++;
    results();
  end
endmodule
